/* gpa_pkg.sv */
// Package of constants for the four-bit input port with interrupts
//****************************************************************
// Contract
// - Debounced level accepted after two stable ticks
// - Edge select 0 rising, 1 falling
// - Bypass 0 debounced, 1 direct, per bit
// - Mask 0 stores no new request
// - All mask bits clear after reset
// - Only edges after unmasking are stored
// - Write one clears flag, zero ignored
// - Edge select change may set flag
// - Pull disable 1 removes fitted pull
// - Bits 0..2 give debounced test variables
// - Bits 0,3 clock event counter, configured
// - Bit 3 gives raw counter start/stop
// - Status register reads live pin levels
// - Sleep watches reset combination, wakes
// - Clock select 0 div 256, 1 div 32
//****************************************************************
package gpa_pkg;

   //****************************************************************
   // Register byte addresses
   //****************************************************************
   localparam logic [7:0] ADDR_LEVEL  = 8'h00;
   localparam logic [7:0] ADDR_MASK   = 8'h04;
   localparam logic [7:0] ADDR_FLAGS  = 8'h08;
   localparam logic [7:0] ADDR_EDGE   = 8'h0C;
   localparam logic [7:0] ADDR_BYPASS = 8'h10;
   localparam logic [7:0] ADDR_PULL   = 8'h14;
   localparam logic [7:0] ADDR_PRESC  = 8'h18;
   localparam logic [7:0] ADDR_COMBO  = 8'h1C;

   //****************************************************************
   // Register index codes used by the decoder
   //****************************************************************
   typedef enum {
      REG_LEVEL, REG_MASK, REG_FLAGS, REG_EDGE, REG_BYPASS,
      REG_PULL, REG_PRESC, REG_COMBO, REG_NONE
   } gpa_reg_t;

   //****************************************************************
   // Field positions and reset values
   //****************************************************************
   localparam int         PRESC_DEB_SEL_BIT = 0;
   localparam int         COMBO_SEL_LSB     = 0;
   localparam int         COMBO_LVL_LSB     = 4;
   localparam logic [3:0] RST_NIBBLE        = 4'h0;
   localparam logic [7:0] RST_COMBO         = 8'h00;

   //****************************************************************
   // Debounce clock dividers (system clock cycles per tick)
   //****************************************************************
   localparam int         DIV_SLOW       = 256;
   localparam int         DIV_FAST       = 32;
   localparam logic [7:0] DIV_SLOW_LAST  = 8'(DIV_SLOW - 1);
   localparam logic [4:0] DIV_FAST_LAST  = 5'(DIV_FAST - 1);

   //****************************************************************
   // Bus responses
   //****************************************************************
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

/* gpa_input_port.sv */
// Four-bit input port with debouncers, edge interrupts and AXI4-Lite
//
// Chosen here: the register offsets and the AXI4-Lite slave port.
`timescale 1ns/1ps
module gpa_input_port #(
   parameter logic [3:0] MASK_FITTED_PULLUP   = 4'h0,
   parameter logic [3:0] MASK_FITTED_PULLDOWN = 4'hF
) (
   // Clock and reset
   input  wire logic        aclk,
   input  wire logic        aresetn,
   // AXI4-Lite write address
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output      logic        s_axi_awready,
   // AXI4-Lite write data
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output      logic        s_axi_wready,
   // AXI4-Lite write response
   output      logic [1:0]  s_axi_bresp,
   output      logic        s_axi_bvalid,
   input  wire logic        s_axi_bready,
   // AXI4-Lite read address
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output      logic        s_axi_arready,
   // AXI4-Lite read data
   output      logic [31:0] s_axi_rdata,
   output      logic [1:0]  s_axi_rresp,
   output      logic        s_axi_rvalid,
   input  wire logic        s_axi_rready,
   // Port pins and pull control
   input  wire logic [3:0]  input_pins,
   output      logic [3:0]  pullup_on,
   output      logic [3:0]  pulldown_on,
   // CPU and counter side
   output      logic        branch_test_one,
   output      logic        branch_test_two,
   output      logic        branch_test_three,
   output      logic        event_clock_bit0,
   output      logic        event_clock_bit3,
   output      logic        msc_start_stop,
   // Sleep and interrupt
   input  wire logic        sleep_mode,
   output      logic        wake_request,
   output      logic        irq
);

   //****************************************************************
   // Declarations
   //****************************************************************
   logic [3:0]  mask_q, flags_q, edge_q, bypass_q, pull_off_q;
   logic        deb_sel_q;
   logic [7:0]  combo_q;
   logic [7:0]  presc_q;
   logic        deb_tick;
   logic [3:0]  cand_q, deb_q, eff_q;
   logic [3:0]  src, eff, edge_evt, set_evt, clr_req;
   logic        aw_have_q, w_have_q, bvalid_q, rvalid_q;
   logic [7:0]  awaddr_q;
   logic [31:0] wdata_q, rdata_q;
   logic [3:0]  wstrb_q;
   logic [1:0]  bresp_q, rresp_q;
   logic        wr_fire;
   gpa_pkg::gpa_reg_t wr_reg, rd_reg;
   logic [7:0]  wr_byte;
   logic        ec0_q, ec3_q, msc_q, wake_q;
   logic [2:0]  test_q;

   // Map a byte address onto a register index
   function automatic gpa_pkg::gpa_reg_t decode(input logic [7:0] addr);
      case (addr)
         gpa_pkg::ADDR_LEVEL:  decode = gpa_pkg::REG_LEVEL;
         gpa_pkg::ADDR_MASK:   decode = gpa_pkg::REG_MASK;
         gpa_pkg::ADDR_FLAGS:  decode = gpa_pkg::REG_FLAGS;
         gpa_pkg::ADDR_EDGE:   decode = gpa_pkg::REG_EDGE;
         gpa_pkg::ADDR_BYPASS: decode = gpa_pkg::REG_BYPASS;
         gpa_pkg::ADDR_PULL:   decode = gpa_pkg::REG_PULL;
         gpa_pkg::ADDR_PRESC:  decode = gpa_pkg::REG_PRESC;
         gpa_pkg::ADDR_COMBO:  decode = gpa_pkg::REG_COMBO;
         default:              decode = gpa_pkg::REG_NONE;
      endcase
   endfunction

   //****************************************************************
   // AXI4-Lite write path
   //****************************************************************
   // Address and data are taken in either order, then answered
   assign s_axi_awready = !aw_have_q && !bvalid_q;
   assign s_axi_wready  = !w_have_q && !bvalid_q;
   assign wr_fire       = aw_have_q && w_have_q && !bvalid_q;
   assign wr_reg        = decode(awaddr_q);
   assign wr_byte       = wstrb_q[0] ? wdata_q[7:0] : 8'h00;
   assign s_axi_bvalid  = bvalid_q;
   assign s_axi_bresp   = bresp_q;

   // Write channel capture and response
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_have_q <= 1'b0;
         w_have_q  <= 1'b0;
         bvalid_q  <= 1'b0;
         awaddr_q  <= 8'h00;
         wdata_q   <= 32'h0000_0000;
         wstrb_q   <= 4'h0;
         bresp_q   <= gpa_pkg::RESP_OKAY;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_have_q <= 1'b1;
            awaddr_q  <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_have_q <= 1'b1;
            wdata_q  <= s_axi_wdata;
            wstrb_q  <= s_axi_wstrb;
         end
         if (wr_fire) begin
            aw_have_q <= 1'b0;
            w_have_q  <= 1'b0;
            bvalid_q  <= 1'b1;
            bresp_q   <= (wr_reg == gpa_pkg::REG_NONE) ? gpa_pkg::RESP_SLVERR
                                                       : gpa_pkg::RESP_OKAY;
         end else if (bvalid_q && s_axi_bready) begin
            bvalid_q <= 1'b0;
         end
      end
   end

   //****************************************************************
   // Configuration registers
   //****************************************************************
   // Software writable settings, low byte lane only
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         mask_q     <= gpa_pkg::RST_NIBBLE;
         edge_q     <= gpa_pkg::RST_NIBBLE;
         bypass_q   <= gpa_pkg::RST_NIBBLE;
         pull_off_q <= gpa_pkg::RST_NIBBLE;
         deb_sel_q  <= 1'b0;
         combo_q    <= gpa_pkg::RST_COMBO;
      end else if (wr_fire && wstrb_q[0]) begin
         case (wr_reg)
            gpa_pkg::REG_MASK:   mask_q     <= wr_byte[3:0];
            gpa_pkg::REG_EDGE:   edge_q     <= wr_byte[3:0];
            gpa_pkg::REG_BYPASS: bypass_q   <= wr_byte[3:0];
            gpa_pkg::REG_PULL:   pull_off_q <= wr_byte[3:0];
            gpa_pkg::REG_PRESC:
               deb_sel_q <= wr_byte[gpa_pkg::PRESC_DEB_SEL_BIT];
            gpa_pkg::REG_COMBO:  combo_q    <= wr_byte;
            default:             mask_q     <= mask_q;
         endcase
      end
   end

   //****************************************************************
   // AXI4-Lite read path
   //****************************************************************
   assign s_axi_arready = !rvalid_q;
   assign rd_reg        = decode(s_axi_araddr);
   assign s_axi_rvalid  = rvalid_q;
   assign s_axi_rdata   = rdata_q;
   assign s_axi_rresp   = rresp_q;

   // Read data capture, live pin levels for the status register
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rvalid_q <= 1'b0;
         rdata_q  <= 32'h0000_0000;
         rresp_q  <= gpa_pkg::RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         rvalid_q <= 1'b1;
         rresp_q  <= gpa_pkg::RESP_OKAY;
         rdata_q  <= 32'h0000_0000;
         case (rd_reg)
            gpa_pkg::REG_LEVEL:  rdata_q[3:0] <= input_pins;
            gpa_pkg::REG_MASK:   rdata_q[3:0] <= mask_q;
            gpa_pkg::REG_FLAGS:  rdata_q[3:0] <= flags_q;
            gpa_pkg::REG_EDGE:   rdata_q[3:0] <= edge_q;
            gpa_pkg::REG_BYPASS: rdata_q[3:0] <= bypass_q;
            gpa_pkg::REG_PULL:   rdata_q[3:0] <= pull_off_q;
            gpa_pkg::REG_PRESC:  rdata_q[0]   <= deb_sel_q;
            gpa_pkg::REG_COMBO:  rdata_q[7:0] <= combo_q;
            default:             rresp_q      <= gpa_pkg::RESP_SLVERR;
         endcase
      end else if (rvalid_q && s_axi_rready) begin
         rvalid_q <= 1'b0;
      end
   end

   //****************************************************************
   // Debounce clock prescaler
   //****************************************************************
   // Free divider, tick every 256 or 32 system clocks
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         presc_q <= 8'h00;
      end else begin
         presc_q <= presc_q + 8'h01;
      end
   end

   assign deb_tick = deb_sel_q ? (presc_q[4:0] == gpa_pkg::DIV_FAST_LAST)
                               : (presc_q == gpa_pkg::DIV_SLOW_LAST);

   //****************************************************************
   // Per-bit debounce, edge detection and flags
   //****************************************************************
   assign clr_req = (wr_fire && wstrb_q[0] && wr_reg == gpa_pkg::REG_FLAGS)
                  ? wr_byte[3:0] : 4'h0;

   for (genvar n = 0; n < 4; n++) begin : g_bit
      // Level accepted once two ticks in a row see the same value
      always_ff @(posedge aclk) begin
         if (!aresetn) begin
            cand_q[n] <= 1'b0;
            deb_q[n]  <= 1'b0;
         end else if (deb_tick) begin
            cand_q[n] <= input_pins[n];
            if (input_pins[n] == cand_q[n]) begin
               deb_q[n] <= input_pins[n];
            end
         end
      end

      // Source and polarity, rise of eff is the active edge
      assign src[n] = bypass_q[n] ? input_pins[n] : deb_q[n];
      assign eff[n] = src[n] ^ edge_q[n];
      assign edge_evt[n] = eff[n] && !eff_q[n];
      assign set_evt[n]  = edge_evt[n] && mask_q[n];

      // Previous polarity-adjusted level
      always_ff @(posedge aclk) begin
         if (!aresetn) begin
            eff_q[n] <= 1'b0;
         end else begin
            eff_q[n] <= eff[n];
         end
      end

      // Sticky request flag, a new edge beats a clear
      always_ff @(posedge aclk) begin
         if (!aresetn) begin
            flags_q[n] <= 1'b0;
         end else if (set_evt[n]) begin
            flags_q[n] <= 1'b1;
         end else if (clr_req[n]) begin
            flags_q[n] <= 1'b0;
         end
      end

      // Pull drive: fitted resistor unless disabled, also in sleep
      assign pullup_on[n]   = MASK_FITTED_PULLUP[n] && !pull_off_q[n];
      assign pulldown_on[n] = MASK_FITTED_PULLDOWN[n] && !pull_off_q[n]
                            && !MASK_FITTED_PULLUP[n];

      chk_flag_needs_edge: assert property (@(posedge aclk)
         disable iff (!aresetn)
         $rose(flags_q[n]) |-> $past(mask_q[n]) && $past(edge_evt[n]))
         else $error("flag set without unmasked edge");
      chk_masked_no_store: assert property (@(posedge aclk)
         disable iff (!aresetn)
         !mask_q[n] && !flags_q[n] |=> !flags_q[n])
         else $error("masked edge stored a flag");
      chk_unmasked_edge_stored: assert property (@(posedge aclk)
         disable iff (!aresetn)
         edge_evt[n] && mask_q[n] |=> flags_q[n])
         else $error("unmasked edge not stored");
      chk_one_clears_flag: assert property (@(posedge aclk)
         disable iff (!aresetn)
         clr_req[n] && !set_evt[n] |=> !flags_q[n])
         else $error("write one did not clear flag");
      chk_set_beats_clear: assert property (@(posedge aclk)
         disable iff (!aresetn)
         clr_req[n] && set_evt[n] |=> flags_q[n])
         else $error("clear won over new edge");
      chk_direct_source: assert property (@(posedge aclk)
         disable iff (!aresetn)
         bypass_q[n] && $changed(input_pins[n]) && !$changed(edge_q[n])
         |-> edge_evt[n] == (input_pins[n] ^ edge_q[n]))
         else $error("direct input edge missed");
      chk_debounce_stable: assert property (@(posedge aclk)
         disable iff (!aresetn)
         $changed(deb_q[n]) |-> $past(deb_tick)
         && $past(input_pins[n]) == $past(cand_q[n]))
         else $error("debounced level changed unstable");
      chk_edge_flip_irq: assert property (@(posedge aclk)
         disable iff (!aresetn)
         !src[n] && $rose(edge_q[n]) && !$past(src[n]) && mask_q[n]
         |=> flags_q[n])
         else $error("edge select change did not set flag");
      chk_pull_off: assert property (@(posedge aclk)
         disable iff (!aresetn)
         pull_off_q[n] |-> !pullup_on[n] && !pulldown_on[n])
         else $error("pull active while disabled");
      chk_pull_exclusive: assert property (@(posedge aclk)
         disable iff (!aresetn)
         !(pullup_on[n] && pulldown_on[n]))
         else $error("pull-up and pull-down both on");
   end

   //****************************************************************
   // CPU test variables, counter clocks and millisecond control
   //****************************************************************
   // Registered copies of the derived signals
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         test_q <= 3'h0;
         ec0_q  <= 1'b0;
         ec3_q  <= 1'b0;
         msc_q  <= 1'b0;
      end else begin
         test_q <= deb_q[2:0];
         ec0_q  <= eff[0];
         ec3_q  <= eff[3];
         msc_q  <= input_pins[3];
      end
   end

   assign branch_test_one   = test_q[0];
   assign branch_test_two   = test_q[1];
   assign branch_test_three = test_q[2];
   assign event_clock_bit0  = ec0_q;
   assign event_clock_bit3  = ec3_q;
   assign msc_start_stop    = msc_q;

   //****************************************************************
   // Sleep wake-up and interrupt output
   //****************************************************************
   // Wake when all selected pins sit at their programmed levels
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         wake_q <= 1'b0;
      end else begin
         wake_q <= sleep_mode && (combo_q[3:0] != 4'h0)
                && (((input_pins ^ combo_q[7:4]) & combo_q[3:0]) == 4'h0);
      end
   end

   assign wake_request = wake_q;
   assign irq          = |(flags_q & mask_q);

   chk_mask_reset: assert property (@(posedge aclk)
      !aresetn |=> mask_q == 4'h0 && flags_q == 4'h0)
      else $error("mask or flags not cleared by reset");
   chk_test_vars: assert property (@(posedge aclk)
      disable iff (!aresetn)
      $past(aresetn) |-> test_q == $past(deb_q[2:0]))
      else $error("test variable not debounced level");
   chk_event_clock0: assert property (@(posedge aclk)
      disable iff (!aresetn)
      $past(aresetn) |-> event_clock_bit0 == (($past(bypass_q[0])
      ? $past(input_pins[0]) : $past(deb_q[0])) ^ $past(edge_q[0])))
      else $error("event clock bit 0 wrong source");
   chk_event_clock3: assert property (@(posedge aclk)
      disable iff (!aresetn)
      $past(aresetn) |-> event_clock_bit3 == (($past(bypass_q[3])
      ? $past(input_pins[3]) : $past(deb_q[3])) ^ $past(edge_q[3])))
      else $error("event clock bit 3 wrong source");
   chk_msc_raw: assert property (@(posedge aclk)
      disable iff (!aresetn)
      $past(aresetn) |-> msc_start_stop == $past(input_pins[3]))
      else $error("start/stop not raw pin level");
   chk_tick_spacing: assert property (@(posedge aclk)
      disable iff (!aresetn)
      deb_tick |=> !deb_tick [*8])
      else $error("debounce ticks too close");
   chk_wake_match: assert property (@(posedge aclk)
      disable iff (!aresetn)
      sleep_mode && combo_q[3:0] != 4'h0
      && ((input_pins ^ combo_q[7:4]) & combo_q[3:0]) == 4'h0
      |=> wake_request)
      else $error("no wake on matching combination");
   chk_wake_sleep_only: assert property (@(posedge aclk)
      disable iff (!aresetn)
      !sleep_mode |=> !wake_request)
      else $error("wake request outside sleep");
   chk_level_read: assert property (@(posedge aclk)
      disable iff (!aresetn)
      s_axi_arvalid && s_axi_arready && rd_reg == gpa_pkg::REG_LEVEL
      |=> s_axi_rvalid && s_axi_rdata[3:0] == $past(input_pins))
      else $error("status read not live pins");

endmodule

/* gpa_pin_model.sv */
// Switch-side model that drives or releases the four input pins
`timescale 1ns/1ps
module gpa_pin_model (
   // Clock
   input  wire logic       aclk,
   // Switch settings from the bench
   input  wire logic [3:0] drive_en,
   input  wire logic [3:0] drive_val,
   // Pull state reported by the port
   input  wire logic [3:0] pullup_on,
   input  wire logic [3:0] pulldown_on,
   // Resolved pin levels
   output      logic [3:0] input_pins
);
   logic [3:0] float_q = 4'h0;

   // Open pins wander every cycle, never a steady level
   always_ff @(posedge aclk) begin
      float_q <= ~float_q;
   end

   // Driven level, else pull level, else wandering level
   always_comb begin
      for (int i = 0; i < 4; i++) begin
         if (drive_en[i]) input_pins[i] = drive_val[i];
         else if (pullup_on[i]) input_pins[i] = 1'b1;
         else if (pulldown_on[i]) input_pins[i] = 1'b0;
         else input_pins[i] = float_q[i];
      end
   end
endmodule

/* gpa_input_port_tb_top.sv */
// Self-checking bench for the four-bit input port
`timescale 1ns/1ps
module gpa_input_port_tb_top;
   localparam logic [7:0] A_LVL = gpa_pkg::ADDR_LEVEL;
   localparam logic [7:0] A_MSK = gpa_pkg::ADDR_MASK;
   localparam logic [7:0] A_FLG = gpa_pkg::ADDR_FLAGS;
   localparam logic [7:0] A_EDG = gpa_pkg::ADDR_EDGE;
   localparam logic [7:0] A_BYP = gpa_pkg::ADDR_BYPASS;
   localparam logic [7:0] A_PUL = gpa_pkg::ADDR_PULL;
   localparam logic [1:0] ERR   = gpa_pkg::RESP_SLVERR;
   logic        aclk = 1'b0;
   logic        aresetn = 1'b0;
   logic [7:0]  awaddr = 8'h00;
   logic [7:0]  araddr = 8'h00;
   logic        awvalid = 1'b0;
   logic        wvalid = 1'b0;
   logic        arvalid = 1'b0;
   logic        bready = 1'b1;
   logic        rready = 1'b1;
   logic        sleep_mode = 1'b0;
   logic [31:0] wdata = 32'h0;
   logic [3:0]  drive_en = 4'hF;
   logic [3:0]  drive_val = 4'h0;
   logic        awready, wready, bvalid, arready, rvalid;
   logic [1:0]  bresp, rresp;
   logic [31:0] rdata;
   logic [3:0]  pins, pu, pd;
   logic        bt1, bt2, bt3, ev0, ev3, millisecond_counter, wake, irq;
   logic [33:0] rd_q[$];
   logic [1:0]  wr_q[$];
   logic [33:0] er;
   logic [1:0]  ew;
   logic [31:0] v;
   integer      seed = 32'hf9dc47cb;
   int          fail_count = 0;
   int          comparisons = 0;
   int          cycles = 0;
   int          n, dv, idle;
   logic [7:0]  regs[6] = '{A_MSK, A_EDG, A_BYP, A_PUL,
                             gpa_pkg::ADDR_PRESC, gpa_pkg::ADDR_COMBO};

   // Design and pin-side model
   gpa_input_port #(.MASK_FITTED_PULLUP(4'h3), .MASK_FITTED_PULLDOWN(4'hC))
   DUT (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
      .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready), .input_pins(pins), .pullup_on(pu),
      .pulldown_on(pd), .branch_test_one(bt1), .branch_test_two(bt2),
      .branch_test_three(bt3), .event_clock_bit0(ev0),
      .event_clock_bit3(ev3), .msc_start_stop(millisecond_counter),
      .sleep_mode(sleep_mode), .wake_request(wake), .irq(irq));
   gpa_pin_model PINS (.aclk(aclk), .drive_en(drive_en),
      .drive_val(drive_val), .pullup_on(pu), .pulldown_on(pd),
      .input_pins(pins));

   // Clock, 100 ns period
   always #50 aclk = ~aclk;

   // Comparison with mismatch report
   task automatic check(string what, logic [31:0] got, logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         fail_count++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask

   // Verdict and end of run
   task automatic tally_and_finish;
      $display("comparisons %0d mismatches %0d", comparisons, fail_count);
      if (fail_count == 0 && comparisons > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   // Bus write, expected response noted in a queue
   task automatic wr(logic [7:0] a, logic [31:0] d, logic [1:0] r = 2'h0);
      wr_q.push_back(r);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      do begin
         @(posedge aclk);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
      end while (!bvalid);
   endtask

   // Bus read, expected data and response noted in a queue
   task automatic rd(logic [7:0] a, logic [31:0] d, logic [1:0] r = 2'h0);
      rd_q.push_back({d, r});
      araddr <= a;
      arvalid <= 1'b1;
      do begin
         @(posedge aclk);
         if (arvalid && arready) arvalid <= 1'b0;
      end while (!rvalid);
   endtask

   // Lets register updates land, then waits
   task automatic idle_for(int c);
      repeat (c) @(posedge aclk);
   endtask

   // Response watcher takes the oldest note and compares
   always @(posedge aclk) begin
      if (rvalid && rready) begin
         er = rd_q.pop_front();
         check("rdata", rdata, er[33:2]);
         check("rresp", rresp, er[1:0]);
      end
      if (bvalid && bready) begin
         ew = wr_q.pop_front();
         check("bresp", bresp, ew);
      end
   end

   // Hang guard
   always @(posedge aclk) begin
      cycles++;
      if (cycles == 20000) begin
         fail_count++;
         tally_and_finish();
      end
   end

   //****************************************************************
   // Main sequence
   //****************************************************************
   initial begin
      idle_for(2);
      aresetn <= 1'b1;
      idle_for(1);
      foreach (regs[i]) rd(regs[i], 32'h0);
      rd(A_FLG, 32'h0);
      rd(8'h20, 32'h0, ERR);
      wr(8'h20, 32'h1, ERR);
      check("pullup", pu, 4'h3);
      check("pulldown", pd, 4'hC);
      wr(A_PUL, 32'h5);
      idle_for(2);
      check("pullup", pu, 4'h2);
      check("pulldown", pd, 4'h8);
      rd(A_PUL, 32'h5);
      drive_en <= 4'hD;
      idle_for(3);
      rd(A_LVL, 32'h2);
      drive_en <= 4'hF;
      $display("test pull done");
      repeat (4) begin
         v = $random(seed);
         drive_val <= v[3:0];
         idle_for(2);
         rd(A_LVL, {28'h0, v[3:0]});
      end
      $display("test level done");
      wr(A_BYP, 32'hF);
      drive_val <= 4'h0;
      idle_for(3);
      drive_val <= 4'hF;
      idle_for(3);
      rd(A_FLG, 32'h0);
      wr(A_MSK, 32'hF);
      rd(A_FLG, 32'h0);
      for (int p = 0; p < 2; p++) begin
         idle = p ? 4'hF : 4'h0;
         wr(A_MSK, 32'h0);
         wr(A_EDG, idle);
         drive_val <= idle[3:0];
         idle_for(3);
         wr(A_FLG, 32'hF);
         wr(A_MSK, 32'hF);
         for (int i = 0; i < 4; i++) begin
            drive_val <= idle[3:0] ^ (4'h1 << i);
            idle_for(3);
            check("irq_set", irq, 1'b1);
            rd(A_FLG, 32'h1 << i);
            wr(A_FLG, 32'h0);
            rd(A_FLG, 32'h1 << i);
            wr(A_FLG, 32'h1 << i);
            idle_for(2);
            check("irq_clr", irq, 1'b0);
            drive_val <= idle[3:0];
            idle_for(3);
            rd(A_FLG, 32'h0);
         end
      end
      $display("test edges done");
      wr(A_MSK, 32'h0);
      wr(A_EDG, 32'h0);
      drive_val <= 4'h0;
      idle_for(3);
      wr(A_FLG, 32'hF);
      wr(A_MSK, 32'h1);
      wr(A_EDG, 32'h1);
      idle_for(2);
      check("irq_swap", irq, 1'b1);
      rd(A_FLG, 32'h1);
      wr(A_EDG, 32'h0);
      wr(A_FLG, 32'h1);
      fork
         wr(A_FLG, 32'h1);
         begin
            @(posedge aclk);
            drive_val <= 4'h1;
         end
      join
      rd(A_FLG, 32'h1);
      check("irq_keep", irq, 1'b1);
      wr(A_MSK, 32'h0);
      wr(A_EDG, 32'h8);
      drive_val <= 4'h9;
      idle_for(3);
      check("event0", ev0, 1'b1);
      check("event3", ev3, 1'b0);
      check("start_stop", millisecond_counter, 1'b1);
      wr(A_BYP, 32'h0);
      wr(A_EDG, 32'h0);
      drive_val <= 4'h0;
      idle_for(3);
      check("start_stop", millisecond_counter, 1'b0);
      $display("test counter inputs done");
      idle_for(600);
      for (int s = 1; s >= 0; s--) begin
         dv = s ? gpa_pkg::DIV_FAST : gpa_pkg::DIV_SLOW;
         v = s ? 32'h7 : 32'h0;
         wr(gpa_pkg::ADDR_PRESC, s);
         wr(A_FLG, 32'hF);
         wr(A_MSK, 32'h1);
         drive_val <= v[3:0];
         n = 0;
         while (bt1 !== v[0] && n < 1000) begin
            @(posedge aclk);
            n++;
            if (n == 3) check("irq_early", irq, 1'b0);
         end
         check("deb_time", n >= dv + 2 && n <= 2 * dv + 3, 1'b1);
         idle_for(3);
         check("tests", {bt3, bt2, bt1}, v[2:0]);
         rd(A_FLG, {31'h0, v[0]});
      end
      $display("test debounce done");
      wr(A_MSK, 32'h0);
      wr(8'h1C, 32'h99);
      drive_val <= 4'h9;
      sleep_mode <= 1'b1;
      idle_for(3);
      check("wake", wake, 1'b1);
      check("sleep_pull", pd, 4'h8);
      drive_val <= 4'h8;
      idle_for(3);
      check("wake", wake, 1'b0);
      sleep_mode <= 1'b0;
      $display("test sleep done");
      idle_for(3);
      tally_and_finish();
   end
endmodule
